// File: bench/sct_host_model.sv
`timescale 1ns/1ns
module sct_host_model #(
    parameter int HALF_INT = 50,
    parameter int HALF_EXT = 156
) (
    // Clock
    input wire logic aclk,
    // Interrupt line and the edge the host listens for
    input wire logic irq_pin,
    input wire logic rise_edge,
    // Sleep oscillators and edges seen
    output logic osc_int,
    output logic osc_ext,
    output int edge_count
);
    int cnt_int = 0;
    int cnt_ext = 0;
    logic irq_prev = 1'b1;
    logic hit;
    assign hit = rise_edge ? irq_pin && !irq_prev : !irq_pin && irq_prev;
    initial
    begin
        osc_int = 1'b0;
        osc_ext = 1'b0;
        edge_count = 0;
    end
    // Sleep oscillators run free; they never stop between uses.
    always @(posedge aclk)
    begin
        cnt_int <= (cnt_int == HALF_INT - 1) ? 0 : cnt_int + 1;
        cnt_ext <= (cnt_ext == HALF_EXT - 1) ? 0 : cnt_ext + 1;
        if (cnt_int == HALF_INT - 1)
            osc_int <= ~osc_int;
        if (cnt_ext == HALF_EXT - 1)
            osc_ext <= ~osc_ext;
        irq_prev <= irq_pin;
        if (hit)
            edge_count <= edge_count + 1;
    end
endmodule

// File: bench/sleep_clock_timer_calibration_bench.sv
`timescale 1ns/1ns
module sleep_clock_timer_calibration_bench;
    import sct_pkg::*;
    localparam int HALF_INT = 50;
    localparam int HALF_EXT = 156;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [ADDR_W-1:0] awaddr = '0;
    logic [ADDR_W-1:0] araddr = '0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic arvalid = 1'b0;
    logic [31:0] wdata = '0;
    logic [31:0] rdata;
    logic awready, wready, bvalid, arready, rvalid, irq_pin;
    logic [1:0] bresp, rresp, last_bresp;
    logic [33:0] rd_word;
    logic [2:0] radio_state_field = 3'h0;
    logic [7:0] averaged_signal_strength_avg = 8'h00;
    logic osc_int, osc_ext;
    logic host_rise = 1'b0;
    int irq_edges;
    sct_sleep_out_s sleep_out;
    int err_count = 0;
    int samples_checked = 0;
    int cycles = 0;

    always #50 aclk = ~aclk;

    sct_sleep_timer i_dut (.aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(4'h1), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(1'b1),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(1'b1),
        .sleep_osc_int(osc_int), .sleep_osc_ext(osc_ext),
        .radio_state_field(radio_state_field), .averaged_signal_strength_avg(averaged_signal_strength_avg),
        .sleep_out(sleep_out), .irq_pin(irq_pin));

    sct_host_model #(.HALF_INT(HALF_INT), .HALF_EXT(HALF_EXT)) i_host (
        .aclk(aclk),
        .irq_pin(irq_pin), .rise_edge(host_rise), .osc_int(osc_int),
        .osc_ext(osc_ext), .edge_count(irq_edges));

    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Ready is sampled at the falling edge so the handshake edge is known.
    // Each transfer opens on a rising edge, even after a falling-edge wait.
    task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d);
        logic a_done;
        logic w_done;
        a_done = 1'b0;
        w_done = 1'b0;
        @(posedge aclk);
        awaddr <= {idx, 2'b00};
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(a_done && w_done))
        begin
            @(negedge aclk);
            a_done = a_done || awready;
            w_done = w_done || wready;
            @(posedge aclk);
            awvalid <= !a_done;
            wvalid <= !w_done;
        end
        do @(negedge aclk); while (!bvalid);
        last_bresp = bresp;
        @(posedge aclk);
    endtask

    task automatic rd(input logic [IDX_W-1:0] idx);
        @(posedge aclk);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        do @(negedge aclk); while (!arready);
        @(posedge aclk);
        arvalid <= 1'b0;
        do @(negedge aclk); while (!rvalid);
        rd_word = {rresp, rdata};
        @(posedge aclk);
    endtask

    task automatic rdchk(input logic [IDX_W-1:0] idx, input logic [7:0] exp);
        rd(idx);
        chk(rd_word, {26'h0, exp});
    endtask

    task automatic t_reset;
        @(negedge aclk);
        chk(sleep_out, 4'b1010);
        chk(irq_pin, 1'b1);
        rdchk(IDX_WAKE_LOW, 8'h0a);
        rdchk(IDX_WAKE_HIGH, 8'h00);
        rdchk(IDX_SLEEP_CTL_B, 8'h00);
        rd(10'h3ff);
        chk(rd_word, {2'b10, 32'h0});
        wr(10'h3ff, 8'h55);
        chk(last_bresp, 2'b10);
    endtask

    task automatic t_status;
        for (int i = 0; i < 8; i++)
        begin
            radio_state_field <= i[2:0];
            averaged_signal_strength_avg <= 8'(i * 37 + 3);
            rdchk(IDX_RADIO_STATE, {i[2:0], 5'h0});
            rdchk(IDX_SIG_STRENGTH, 8'(i * 37 + 3));
        end
    endtask

    task automatic t_cal;
        logic [19:0] cal;
        cal = 20'(CAL_PERIODS * HALF_INT * 4 * TICKS_PER_CLK);
        wr(IDX_RADIO_CTL7, {SRC_INT, 6'h0});
        chk(last_bresp, RESP_OKAY);
        rdchk(IDX_RADIO_CTL7, 8'h80);
        wr(IDX_SLEEP_CTL_B, 8'h01);
        wr(IDX_CAL_HIGH, 8'h10);
        rdchk(IDX_CAL_HIGH, 8'h00);
        do rd(IDX_CAL_HIGH); while (rd_word[7] !== 1'b1);
        chk(rd_word, {26'h0, 4'h8, cal[19:16]});
        rdchk(IDX_CAL_LOW, cal[7:0]);
        rdchk(IDX_CAL_MID, cal[15:8]);
        chk(irq_pin, 1'b1);
        wr(IDX_IRQ_MASK, 8'h01);
        repeat (2) @(negedge aclk);
        chk({irq_pin, 8'(irq_edges)}, {1'b0, 8'h01});
        wr(IDX_IRQ_STATUS, 8'h01);
        chk(irq_pin, 1'b1);
    endtask

    task automatic t_sleep;
        host_rise <= 1'b1;
        wr(IDX_SLEEP_CTL_A, 8'h02);
        rdchk(IDX_SLEEP_CTL_A, 8'h02);
        wr(IDX_IRQ_MASK, 8'h06);
        wr(IDX_MAIN_0, 8'h05);
        wr(IDX_WAKE_LOW, 8'h02);
        wr(IDX_REMAIN_LOW, 8'h0a);
        wr(IDX_MAIN_3, 8'h80);
        do @(negedge aclk); while (!sleep_out.sleeping);
        chk(sleep_out.main_osc_enable, 1'b0);
        do @(negedge aclk); while (!sleep_out.main_osc_enable);
        chk(sleep_out.sleeping, 1'b1);
        do @(negedge aclk); while (sleep_out.sleeping);
        rdchk(IDX_IRQ_STATUS, 8'h06);
        repeat (2) @(negedge aclk);
        chk({irq_pin, 8'(irq_edges)}, {1'b1, 8'h02});
        rdchk(IDX_MAIN_3, 8'h00);
        rdchk(IDX_MAIN_0, 8'h05);
    endtask

    task automatic t_divider;
        int n;
        n = 0;
        wr(IDX_SLEEP_CTL_A, 8'h03);
        repeat (500) @(negedge aclk) n += int'(sleep_out.low_power_clock_tick);
        chk(n, 0);
        wr(IDX_SLEEP_CTL_A, 8'h02);
        wr(IDX_SLEEP_CTL_B, 8'h22);
        chk(sleep_out.clock_pin_enable, 1'b0);
        // The first tick after a restart has no fixed phase, so skip it.
        do @(negedge aclk); while (!sleep_out.low_power_clock_tick);
        n = 0;
        do
        begin
            @(negedge aclk);
            n++;
        end while (!sleep_out.low_power_clock_tick);
        chk(n, 4 * 2 * HALF_INT);
        wr(IDX_RADIO_CTL7, {SRC_EXT, 6'h0});
        do @(negedge aclk); while (!sleep_out.low_power_clock_tick);
        n = 0;
        do
        begin
            @(negedge aclk);
            n++;
        end while (!sleep_out.low_power_clock_tick);
        chk(n, 4 * 2 * HALF_EXT);
    endtask

    always @(posedge aclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            err_count++;
            final_report;
        end
    end

    initial
    begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset;
        t_status;
        t_cal;
        t_sleep;
        t_divider;
        final_report;
    end
endmodule

// File: logic/sct_clk_div.sv
`timescale 1ns/1ns
module sct_clk_div #(
    parameter int DIV_W = 5
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Source edges and control
    input wire logic src_edge,
    input wire logic gate_off,
    input wire logic [DIV_W-1:0] divisor,
    // Divided clock, one pulse per period
    output logic tick
);
    localparam int CNT_W = 2 ** DIV_W - 1;

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic tick;
    } sct_div_s;

    sct_div_s st;
    sct_div_s next_st;
    logic [CNT_W-1:0] limit;

    // Shifting past the top wraps to zero, so the largest divisor still
    // yields 2**n edges per period.
    assign limit = (CNT_W'(1) << divisor) - CNT_W'(1);
    assign tick = st.tick;

    always_comb
    begin
        next_st = st;
        next_st.tick = 1'b0;
        if (gate_off)
        begin
            next_st.cnt = '0;
        end
        else if (src_edge)
        begin
            if (st.cnt >= limit)
            begin
                next_st.cnt = '0;
                next_st.tick = 1'b1;
            end
            else
            begin
                next_st.cnt = st.cnt + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            st <= '0;
        else
            st <= next_st;
    end
endmodule

// File: logic/sct_pkg.sv
package sct_pkg;
    // Bus geometry: the register index is the byte address divided by four.
    localparam int ADDR_W = 12;
    localparam int IDX_W = 10;
    localparam int IDX_LSB = 2;
    localparam int BYTE_W = 8;

    // Register indices.
    localparam logic [IDX_W-1:0] IDX_RADIO_CTL7 = 10'h207;
    localparam logic [IDX_W-1:0] IDX_CAL_LOW = 10'h209;
    localparam logic [IDX_W-1:0] IDX_CAL_MID = 10'h20a;
    localparam logic [IDX_W-1:0] IDX_CAL_HIGH = 10'h20b;
    localparam logic [IDX_W-1:0] IDX_RADIO_STATE = 10'h20f;
    localparam logic [IDX_W-1:0] IDX_SIG_STRENGTH = 10'h210;
    localparam logic [IDX_W-1:0] IDX_SLEEP_CTL_A = 10'h211;
    localparam logic [IDX_W-1:0] IDX_SLEEP_CTL_B = 10'h220;
    localparam logic [IDX_W-1:0] IDX_WAKE_LOW = 10'h222;
    localparam logic [IDX_W-1:0] IDX_WAKE_HIGH = 10'h223;
    localparam logic [IDX_W-1:0] IDX_REMAIN_LOW = 10'h224;
    localparam logic [IDX_W-1:0] IDX_REMAIN_HIGH = 10'h225;
    localparam logic [IDX_W-1:0] IDX_MAIN_0 = 10'h226;
    localparam logic [IDX_W-1:0] IDX_MAIN_1 = 10'h227;
    localparam logic [IDX_W-1:0] IDX_MAIN_2 = 10'h228;
    localparam logic [IDX_W-1:0] IDX_MAIN_3 = 10'h229;
    localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 10'h240;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 10'h241;

    // Field positions.
    localparam int CAL_RDY_BIT = 7;
    localparam int CAL_START_BIT = 4;
    localparam int IRQ_EDGE_BIT = 1;
    localparam int CLK_GATE_BIT = 0;
    localparam int CLKPIN_DIS_BIT = 5;
    localparam int START_CNT_BIT = 7;
    localparam int SRC_LSB = 6;
    localparam int STATE_LSB = 5;

    // Widths and reset values.
    localparam int CAL_W = 20;
    localparam int MAIN_W = 26;
    localparam int WAKE_W = 11;
    localparam int REM_W = 16;
    localparam int DIV_W = 5;
    localparam logic [WAKE_W-1:0] WAKE_RST = 11'h00a;

    // Sleep clock source codes.
    localparam logic [1:0] SRC_INT = 2'h2;
    localparam logic [1:0] SRC_EXT = 2'h1;

    // Interrupt status bits.
    localparam int IRQ_W = 3;
    localparam int IRQ_CAL = 0;
    localparam int IRQ_WAKE = 1;
    localparam int IRQ_DONE = 2;

    // Timing: counters advance in 50 ns ticks on a 100 ns clock.
    localparam int CLK_PERIOD_NS = 100;
    localparam int TICK_NS = 50;
    localparam logic [CAL_W-1:0] TICKS_PER_CLK =
        CAL_W'(CLK_PERIOD_NS / TICK_NS);
    localparam logic [4:0] CAL_PERIODS = 5'h10;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {CAL_IDLE, CAL_ARM, CAL_RUN} sct_cal_e;
    typedef enum logic [1:0] {SL_IDLE, SL_MAIN, SL_REM} sct_sleep_e;

    typedef struct packed {
        logic main_osc_enable;
        logic sleeping;
        logic clock_pin_enable;
        logic low_power_clock_tick;
    } sct_sleep_out_s;
endpackage

// File: logic/sct_sleep_timer.sv
`timescale 1ns/1ns
module sct_sleep_timer (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write channels
    input wire logic [sct_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read channels
    input wire logic [sct_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Sleep clock sources and radio status
    input wire logic sleep_osc_int,
    input wire logic sleep_osc_ext,
    input wire logic [2:0] radio_state_field,
    input wire logic [7:0] averaged_signal_strength_avg,
    // Sleep status and interrupt
    output sct_pkg::sct_sleep_out_s sleep_out,
    output logic irq_pin
);
    import sct_pkg::*;

    typedef struct packed {
        logic aw_full;
        logic [ADDR_W-1:0] aw_addr;
        logic w_full;
        logic [BYTE_W-1:0] w_byte;
        logic w_lane;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic irq_edge;
        logic clk_gate;
        logic clkpin_dis;
        logic [DIV_W-1:0] divisor;
        logic [1:0] src;
        logic [WAKE_W-1:0] wake;
        logic [REM_W-1:0] remain;
        logic [MAIN_W-1:0] main_set;
        logic [IRQ_W-1:0] irq_mask;
        logic [IRQ_W-1:0] irq_stat;
        sct_cal_e cal_st;
        logic [CAL_W-1:0] cal_cnt;
        logic cal_rdy;
        logic [4:0] cal_periods;
        sct_sleep_e sl_st;
        logic [MAIN_W-1:0] main_left;
        logic [REM_W-1:0] rem_left;
        logic osc_en;
        logic src_int_d;
        logic src_ext_d;
    } sct_state_s;

    sct_state_s st;
    sct_state_s next_st;
    logic div_tick;
    logic src_edge;
    logic wr_fire;
    logic [IDX_W-1:0] wr_idx;
    logic [IDX_W-1:0] rd_idx;
    logic [BYTE_W-1:0] rd_byte;
    logic rd_hit;
    logic wr_hit;
    logic irq_level;
    logic [IRQ_W-1:0] irq_set;

    // A source edge is a rising level, the inputs being synchronous.
    always_comb
    begin
        unique case (st.src)
            SRC_INT: src_edge = sleep_osc_int && !st.src_int_d;
            SRC_EXT: src_edge = sleep_osc_ext && !st.src_ext_d;
            default: src_edge = 1'b0;
        endcase
    end

    sct_clk_div #(.DIV_W(DIV_W)) u_div (
        .aclk(aclk),
        .aresetn(aresetn),
        .src_edge(src_edge),
        .gate_off(st.clk_gate),
        .divisor(st.divisor),
        .tick(div_tick)
    );

    assign wr_fire = st.aw_full && st.w_full && !st.bvalid;
    assign wr_idx = st.aw_addr[ADDR_W-1:IDX_LSB];
    assign rd_idx = araddr[ADDR_W-1:IDX_LSB];

    assign awready = !st.aw_full && !st.bvalid;
    assign wready = !st.w_full && !st.bvalid;
    assign bvalid = st.bvalid;
    assign bresp = st.bresp;
    assign arready = !st.rvalid;
    assign rvalid = st.rvalid;
    assign rdata = st.rdata;
    assign rresp = st.rresp;

    // Read decode, least significant byte at the lowest index.
    always_comb
    begin
        rd_hit = 1'b1;
        rd_byte = '0;
        unique case (rd_idx)
            IDX_RADIO_CTL7: rd_byte = {st.src, 6'h00};
            IDX_CAL_LOW: rd_byte = st.cal_cnt[7:0];
            IDX_CAL_MID: rd_byte = st.cal_cnt[15:8];
            IDX_CAL_HIGH: rd_byte = {st.cal_rdy, 3'h0, st.cal_cnt[19:16]};
            IDX_RADIO_STATE: rd_byte = {radio_state_field, 5'h00};
            IDX_SIG_STRENGTH: rd_byte = averaged_signal_strength_avg;
            IDX_SLEEP_CTL_A: rd_byte = {6'h00, st.irq_edge, st.clk_gate};
            IDX_SLEEP_CTL_B: rd_byte = {2'h0, st.clkpin_dis, st.divisor};
            IDX_WAKE_LOW: rd_byte = st.wake[7:0];
            IDX_WAKE_HIGH: rd_byte = {5'h00, st.wake[10:8]};
            IDX_REMAIN_LOW: rd_byte = st.remain[7:0];
            IDX_REMAIN_HIGH: rd_byte = st.remain[15:8];
            IDX_MAIN_0: rd_byte = st.main_set[7:0];
            IDX_MAIN_1: rd_byte = st.main_set[15:8];
            IDX_MAIN_2: rd_byte = st.main_set[23:16];
            IDX_MAIN_3: rd_byte = {6'h00, st.main_set[25:24]};
            IDX_IRQ_STATUS: rd_byte = {5'h00, st.irq_stat};
            IDX_IRQ_MASK: rd_byte = {5'h00, st.irq_mask};
            default: rd_hit = 1'b0;
        endcase
    end

    always_comb
    begin
        unique case (wr_idx)
            IDX_RADIO_CTL7, IDX_CAL_LOW, IDX_CAL_MID, IDX_CAL_HIGH,
            IDX_RADIO_STATE, IDX_SIG_STRENGTH, IDX_SLEEP_CTL_A,
            IDX_SLEEP_CTL_B, IDX_WAKE_LOW, IDX_WAKE_HIGH, IDX_REMAIN_LOW,
            IDX_REMAIN_HIGH, IDX_MAIN_0, IDX_MAIN_1, IDX_MAIN_2,
            IDX_MAIN_3, IDX_IRQ_STATUS, IDX_IRQ_MASK: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_comb
    begin
        next_st = st;
        irq_set = '0;
        next_st.src_int_d = sleep_osc_int;
        next_st.src_ext_d = sleep_osc_ext;

        // Write address and data are held until both halves arrive.
        if (awvalid && awready)
        begin
            next_st.aw_full = 1'b1;
            next_st.aw_addr = awaddr;
        end
        if (wvalid && wready)
        begin
            next_st.w_full = 1'b1;
            next_st.w_byte = wdata[7:0];
            next_st.w_lane = wstrb[0];
        end
        if (st.bvalid && bready)
            next_st.bvalid = 1'b0;
        if (st.rvalid && rready)
            next_st.rvalid = 1'b0;
        if (arvalid && !st.rvalid)
        begin
            next_st.rvalid = 1'b1;
            next_st.rdata = {24'h000000, rd_byte};
            next_st.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end

        // Calibration: wait for a period boundary, then time sixteen.
        unique case (st.cal_st)
            CAL_IDLE: ;
            CAL_ARM:
            begin
                if (div_tick)
                begin
                    next_st.cal_st = CAL_RUN;
                    next_st.cal_cnt = '0;
                    next_st.cal_periods = '0;
                end
            end
            CAL_RUN:
            begin
                // Saturate rather than wrap on a stopped sleep clock.
                if (st.cal_cnt <= ~TICKS_PER_CLK)
                    next_st.cal_cnt = st.cal_cnt + TICKS_PER_CLK;
                else
                    next_st.cal_cnt = '1;
                if (div_tick)
                begin
                    next_st.cal_periods = st.cal_periods + 5'h01;
                    if (st.cal_periods == CAL_PERIODS - 5'h01)
                    begin
                        next_st.cal_st = CAL_IDLE;
                        next_st.cal_rdy = 1'b1;
                        irq_set[IRQ_CAL] = 1'b1;
                    end
                end
            end
        endcase

        // Sleep: main counter in sleep periods, then remain in ticks.
        unique case (st.sl_st)
            SL_IDLE: ;
            SL_MAIN:
            begin
                if (!st.osc_en && st.main_left <= MAIN_W'(st.wake))
                begin
                    next_st.osc_en = 1'b1;
                    irq_set[IRQ_WAKE] = 1'b1;
                end
                if (st.main_left == '0)
                begin
                    next_st.sl_st = SL_REM;
                    next_st.rem_left = st.remain;
                end
                else if (div_tick)
                begin
                    next_st.main_left = st.main_left - MAIN_W'(1);
                end
            end
            SL_REM:
            begin
                if (st.rem_left <= REM_W'(TICKS_PER_CLK))
                begin
                    next_st.sl_st = SL_IDLE;
                    next_st.osc_en = 1'b1;
                    irq_set[IRQ_DONE] = 1'b1;
                end
                else
                begin
                    next_st.rem_left = st.rem_left - REM_W'(TICKS_PER_CLK);
                end
            end
            default: next_st.sl_st = SL_IDLE;
        endcase

        if (wr_fire)
        begin
            next_st.aw_full = 1'b0;
            next_st.w_full = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
        end
        if (wr_fire && st.w_lane)
        begin
            unique case (wr_idx)
                IDX_RADIO_CTL7: next_st.src = st.w_byte[7:6];
                IDX_CAL_HIGH:
                begin
                    if (st.w_byte[CAL_START_BIT])
                    begin
                        next_st.cal_st = CAL_ARM;
                        next_st.cal_rdy = 1'b0;
                        next_st.cal_cnt = '0;
                    end
                end
                IDX_SLEEP_CTL_A:
                begin
                    next_st.irq_edge = st.w_byte[IRQ_EDGE_BIT];
                    next_st.clk_gate = st.w_byte[CLK_GATE_BIT];
                end
                IDX_SLEEP_CTL_B:
                begin
                    next_st.clkpin_dis = st.w_byte[CLKPIN_DIS_BIT];
                    next_st.divisor = st.w_byte[DIV_W-1:0];
                end
                IDX_WAKE_LOW: next_st.wake[7:0] = st.w_byte;
                IDX_WAKE_HIGH: next_st.wake[10:8] = st.w_byte[2:0];
                IDX_REMAIN_LOW: next_st.remain[7:0] = st.w_byte;
                IDX_REMAIN_HIGH: next_st.remain[15:8] = st.w_byte;
                IDX_MAIN_0: next_st.main_set[7:0] = st.w_byte;
                IDX_MAIN_1: next_st.main_set[15:8] = st.w_byte;
                IDX_MAIN_2: next_st.main_set[23:16] = st.w_byte;
                IDX_MAIN_3:
                begin
                    next_st.main_set[25:24] = st.w_byte[1:0];
                    if (st.w_byte[START_CNT_BIT])
                    begin
                        next_st.sl_st = SL_MAIN;
                        next_st.main_left = {st.w_byte[1:0],
                                             st.main_set[23:0]};
                        next_st.osc_en = 1'b0;
                    end
                end
                IDX_IRQ_MASK: next_st.irq_mask = st.w_byte[IRQ_W-1:0];
                IDX_IRQ_STATUS:
                    next_st.irq_stat = st.irq_stat & ~st.w_byte[IRQ_W-1:0];
                default: ;
            endcase
        end
        // A new event outweighs a clear written in the same cycle.
        next_st.irq_stat = next_st.irq_stat | irq_set;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st <= '0;
            st.wake <= WAKE_RST;
            st.osc_en <= 1'b1;
            st.cal_st <= CAL_IDLE;
            st.sl_st <= SL_IDLE;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign irq_level = |(st.irq_stat & st.irq_mask);
    // The pin idles at the opposite level so the first pending unmasked event makes one edge.
    assign irq_pin = st.irq_edge ? irq_level : !irq_level;
    assign sleep_out.main_osc_enable = st.osc_en;
    assign sleep_out.sleeping = st.sl_st != SL_IDLE;
    assign sleep_out.clock_pin_enable = !st.clkpin_dis;
    assign sleep_out.low_power_clock_tick = div_tick;

    property p_cal_start;
        @(posedge aclk) disable iff (!aresetn)
        wr_fire && st.w_lane && wr_idx == IDX_CAL_HIGH
            && st.w_byte[CAL_START_BIT]
        |=> st.cal_st == CAL_ARM && !st.cal_rdy && st.cal_cnt == '0;
    endproperty
    a_cal_start: assert property (p_cal_start)
        else $error("calibration start not taken");

    property p_cal_ready;
        @(posedge aclk) disable iff (!aresetn)
        $rose(st.cal_rdy) |-> $past(st.cal_st) == CAL_RUN
            && $past(st.cal_periods) == 5'h0f && st.irq_stat[IRQ_CAL];
    endproperty
    a_cal_ready: assert property (p_cal_ready)
        else $error("ready flag set without sixteen periods");

    // A restart written during a run clears the count, so it is excluded.
    property p_cal_step;
        @(posedge aclk) disable iff (!aresetn)
        st.cal_st == CAL_RUN && st.cal_cnt <= 20'hffffd
            && !(wr_fire && st.w_lane && wr_idx == IDX_CAL_HIGH
            && st.w_byte[CAL_START_BIT])
        |=> st.cal_cnt == $past(st.cal_cnt) + 20'h00002;
    endproperty
    a_cal_step: assert property (p_cal_step)
        else $error("calibration count did not advance by two ticks");

    property p_irq_rise;
        @(posedge aclk) disable iff (!aresetn)
        st.irq_edge && $stable(st.irq_edge) && $rose(irq_level)
        |-> $rose(irq_pin);
    endproperty
    a_irq_rise: assert property (p_irq_rise)
        else $error("interrupt pin edge has wrong polarity");

    property p_gate_stop;
        @(posedge aclk) disable iff (!aresetn)
        st.clk_gate ##1 st.clk_gate |-> !div_tick;
    endproperty
    a_gate_stop: assert property (p_gate_stop)
        else $error("sleep clock ran while gated");

    property p_pin_off;
        @(posedge aclk) disable iff (!aresetn)
        wr_fire && st.w_lane && wr_idx == IDX_SLEEP_CTL_B
        |=> sleep_out.clock_pin_enable == !$past(st.w_byte[CLKPIN_DIS_BIT]);
    endproperty
    a_pin_off: assert property (p_pin_off)
        else $error("clock pin enable does not follow its bit");

    property p_wake;
        @(posedge aclk) disable iff (!aresetn)
        $rose(st.osc_en) |-> $past(st.sl_st) != SL_IDLE;
    endproperty
    a_wake: assert property (p_wake)
        else $error("oscillator woke outside a sleep");

    property p_wake_reset;
        @(posedge aclk) disable iff (1'b0)
        !aresetn |=> st.wake == 11'h00a && st.osc_en;
    endproperty
    a_wake_reset: assert property (p_wake_reset)
        else $error("wake value not ten after reset");

    property p_sleep_start;
        @(posedge aclk) disable iff (!aresetn)
        wr_fire && st.w_lane && wr_idx == IDX_MAIN_3
            && st.w_byte[START_CNT_BIT]
        |=> st.sl_st == SL_MAIN && !st.osc_en ##1 sleep_out.sleeping;
    endproperty
    a_sleep_start: assert property (p_sleep_start)
        else $error("sleep counters did not start");

    property p_state_read;
        @(posedge aclk) disable iff (!aresetn)
        arvalid && arready && rd_idx == IDX_RADIO_STATE
        |=> rvalid && rdata[7:5] == $past(radio_state_field)
            && rdata[4:0] == 5'h00;
    endproperty
    a_state_read: assert property (p_state_read)
        else $error("radio state readback wrong");

    c_cal_done: cover property (@(posedge aclk) $rose(st.cal_rdy));
    c_wake: cover property (@(posedge aclk) irq_set[IRQ_WAKE]);
    c_sleep_done: cover property (@(posedge aclk) irq_set[IRQ_DONE]);
    c_irq: cover property (@(posedge aclk) irq_level && st.irq_edge);
endmodule
